// File: verilog/hocs_consts.svh
// Constants of the harmonic overcurrent stage
`ifndef HOCS_CONSTS_SVH
`define HOCS_CONSTS_SVH
`define HOCS_HSEL_RST      4'h0
`define HOCS_HSEL_MAX      4'hB
`define HOCS_SET_PU_RST    16'h0014
`define HOCS_SET_REL_RST   16'h07D0
`define HOCS_RESET_NUM     32'h61
`define HOCS_RESET_DEN     32'h64
`define HOCS_CLK_NS        32'h8
`define HOCS_CYCLE_NS      32'h4C4B40
`define HOCS_CYCLE_CLKS    (`HOCS_CYCLE_NS / `HOCS_CLK_NS)
`define HOCS_PRE_SHORT_MS  32'h14
`define HOCS_PRE_LONG_MS   32'hC8
`define HOCS_CYC_MS        32'h5
`define HOCS_PRE_SHORT     (`HOCS_PRE_SHORT_MS / `HOCS_CYC_MS)
`define HOCS_PRE_LONG      (`HOCS_PRE_LONG_MS / `HOCS_CYC_MS)
`define HOCS_REC_DEPTH     12
`define HOCS_STAGES        4
`endif

// File: verilog/hocs_pkg.sv
// Types of the harmonic overcurrent stage
package hocs_pkg;
   typedef enum logic [1:0] {
      HOCS_NORMAL  = 2'h0,
      HOCS_START   = 2'h1,
      HOCS_TRIP    = 2'h3,
      HOCS_BLOCKED = 2'h2
   } hocs_state_t;
   typedef enum logic [1:0] {
      HOCS_IN_PHASE = 2'h0,
      HOCS_IN_RES1  = 2'h1,
      HOCS_IN_RES2  = 2'h2
   } hocs_input_t;
   typedef enum logic [1:0] {
      HOCS_EV_NONE = 2'h0,
      HOCS_EV_ON   = 2'h1,
      HOCS_EV_OFF  = 2'h2,
      HOCS_EV_BOTH = 2'h3
   } hocs_evsel_t;
endpackage

// File: verilog/hocs_harmonic_overcurrent_stage.sv
// Harmonic overcurrent stage, four instances, counters and fault records
`timescale 1ns/100ps
`include "hocs_consts.svh"
module hocs_harmonic_overcurrent_stage #(
   parameter int unsigned CYCLE_CLKS = `HOCS_CYCLE_CLKS
) (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic                     clk_en,
   input  wire logic [3:0]               harm_sel,
   input  wire logic                     rel_mode,
   input  wire hocs_pkg::hocs_input_t    meas_sel,
   input  wire logic                     force_en,
   input  wire hocs_pkg::hocs_state_t    force_state,
   input  wire logic [3:0][15:0]         set_value,
   input  wire logic [3:0][15:0]         op_delay,
   input  wire logic [2:0]               set_group,
   input  wire logic [15:0]              phase_harm [3][12],
   input  wire logic [15:0]              phase_fund [3],
   input  wire logic [15:0]              res1_harm [12],
   input  wire logic [15:0]              res1_fund,
   input  wire logic [15:0]              res2_harm [12],
   input  wire logic [15:0]              res2_fund,
   input  wire logic [3:0]               block_in,
   input  wire logic [5:0]               ev_sel,
   input  wire logic                     cnt_clear,
   input  wire logic [31:0]              timestamp,
   input  wire logic [3:0]               rec_rd_idx,
   output logic [3:0]                    start_out,
   output logic [3:0]                    trip_out,
   output logic [3:0]                    blocked_out,
   output logic [3:0][1:0]               stage_status,
   output logic [3:0][23:0]              ratio_now,
   output logic [3:0][15:0]              time_left,
   output logic [3:0][15:0]              time_expected,
   output logic [3:0][5:0]               event_pulse,
   output logic [3:0][15:0]              start_count,
   output logic [3:0][15:0]              trip_count,
   output logic [3:0][15:0]              blocked_count,
   output logic [31:0]                   rec_time,
   output logic [4:0]                    rec_event,
   output logic [2:0]                    rec_fault,
   output logic [15:0]                   rec_pre_trig,
   output logic [15:0]                   rec_fault_cur,
   output logic [15:0]                   rec_pre_fault,
   output logic [15:0]                   rec_time_left,
   output logic [2:0]                    rec_group,
   output logic [3:0]                    rec_fill
);

   // Replace an out-of-range harmonic index with index 0
   function automatic logic [3:0] hidx(input logic [3:0] s);
      hidx = (s > `HOCS_HSEL_MAX) ? `HOCS_HSEL_RST : s;
   endfunction

   // Monitored value: magnitude or percent of fundamental in 0.01 %
   function automatic logic [15:0] mon(input logic [15:0] h, input logic [15:0] f,
                                       input logic rel);
      logic [31:0] q;
      q = 32'h0;
      if (f != 16'h0)
         q = ({16'h0, h} * 32'h2710) / {16'h0, f};
      mon = rel ? ((q > 32'hFFFF) ? 16'hFFFF : q[15:0]) : h;
   endfunction

   localparam int unsigned CYC = CYCLE_CLKS;
   localparam int unsigned PSH = `HOCS_PRE_SHORT;
   localparam int unsigned PLG = `HOCS_PRE_LONG;

   logic [3:0]  hs;
   logic [15:0] mon_v [3];
   logic [15:0] mon_max;
   logic [2:0]  fault_w;
   assign hs = hidx(harm_sel);

   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_ph
         logic [15:0] h_sel;
         logic [15:0] f_sel;
         assign h_sel = (meas_sel == hocs_pkg::HOCS_IN_RES1) ? (p == 0 ? res1_harm[hs] : 16'h0) :
                        (meas_sel == hocs_pkg::HOCS_IN_RES2) ? (p == 0 ? res2_harm[hs] : 16'h0) :
                        phase_harm[p][hs];
         assign f_sel = (meas_sel == hocs_pkg::HOCS_IN_RES1) ? res1_fund :
                        (meas_sel == hocs_pkg::HOCS_IN_RES2) ? res2_fund :
                        phase_fund[p];
         assign mon_v[p] = mon(h_sel, f_sel, rel_mode);
      end
   endgenerate

   assign mon_max = (mon_v[0] > mon_v[1]) ?
                    ((mon_v[0] > mon_v[2]) ? mon_v[0] : mon_v[2]) :
                    ((mon_v[1] > mon_v[2]) ? mon_v[1] : mon_v[2]);

   // Program cycle tick
   logic [31:0] cyc_q;
   logic        tick;
   assign tick = (cyc_q == CYC - 1);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_q <= 32'h0;
      end else if (clk_en) begin
         cyc_q <= tick ? 32'h0 : cyc_q + 32'h1;
      end
   end

   // Pre-trigger history of the monitored peak
   logic [15:0] hist_q [PLG];
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PLG; i++) hist_q[i] <= 16'h0;
      end else if (clk_en && tick) begin
         hist_q[0] <= mon_max;
         for (int i = 1; i < PLG; i++) hist_q[i] <= hist_q[i-1];
      end
   end

   logic [3:0] rec_req;
   logic [3:0] rec_kind [4];

   genvar s;
   generate
      for (s = 0; s < `HOCS_STAGES; s++) begin : g_st
         logic        pick_q;
         logic        blk_w;
         logic        pick_d;
         logic [15:0] rel_lvl;
         logic [15:0] tmr_q;
         hocs_pkg::hocs_state_t st_q, st_d, st_out;
         logic [31:0] ratio_w;
         // Block taken at the tick edge itself, in the same decision as pick-up
         assign blk_w = block_in[s];
         // Setting read live each cycle
         assign rel_lvl = 16'(({16'h0, set_value[s]} * `HOCS_RESET_NUM) / `HOCS_RESET_DEN);
         assign pick_d = pick_q ? (mon_max >= rel_lvl) : (mon_max > set_value[s]);
         assign ratio_w = (set_value[s] == 16'h0) ? 32'h0 :
                          ({16'h0, mon_max} * 32'h64) / {16'h0, set_value[s]};
         always_comb begin
            st_d = st_q;
            case (st_q)
               hocs_pkg::HOCS_NORMAL:
                  if (pick_d) st_d = blk_w ? hocs_pkg::HOCS_BLOCKED : hocs_pkg::HOCS_START;
               hocs_pkg::HOCS_START:
                  if (!pick_d || blk_w) st_d = hocs_pkg::HOCS_NORMAL;
                  else if (tmr_q == 16'h0 || tmr_q == 16'h1) st_d = hocs_pkg::HOCS_TRIP;
               hocs_pkg::HOCS_TRIP:
                  if (!pick_d) st_d = hocs_pkg::HOCS_NORMAL;
               hocs_pkg::HOCS_BLOCKED:
                  if (!pick_d || !blk_w) st_d = hocs_pkg::HOCS_NORMAL;
               default: st_d = hocs_pkg::HOCS_NORMAL;
            endcase
         end
         assign st_out = force_en ? force_state : st_q;
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               pick_q <= 1'b0;
               st_q   <= hocs_pkg::HOCS_NORMAL;
               tmr_q  <= 16'h0;
            end else if (clk_en && tick) begin
               pick_q <= pick_d;
               st_q   <= st_d;
               tmr_q  <= (st_d == hocs_pkg::HOCS_START) ?
                         ((st_q == hocs_pkg::HOCS_START) ? tmr_q - 16'h1 : op_delay[s]) :
                         16'h0;
            end
         end
         logic [2:0] now_w, was_q;
         logic [5:0] ev_w;
         assign now_w = {st_out == hocs_pkg::HOCS_BLOCKED, st_out == hocs_pkg::HOCS_TRIP,
                         st_out == hocs_pkg::HOCS_START || st_out == hocs_pkg::HOCS_TRIP};
         assign ev_w = {~now_w & was_q, now_w & ~was_q} & ev_sel;
         assign rec_req[s] = |(now_w & ~was_q);
         assign rec_kind[s] = {1'b0, now_w & ~was_q};
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               was_q            <= 3'h0;
               event_pulse[s]   <= 6'h0;
               start_out[s]     <= 1'b0;
               trip_out[s]      <= 1'b0;
               blocked_out[s]   <= 1'b0;
               stage_status[s]  <= 2'h0;
               ratio_now[s]     <= 24'h0;
               time_left[s]     <= 16'h0;
               time_expected[s] <= 16'h0;
               start_count[s]   <= 16'h0;
               trip_count[s]    <= 16'h0;
               blocked_count[s] <= 16'h0;
            end else if (clk_en) begin
               was_q            <= now_w;
               event_pulse[s]   <= ev_w;
               start_out[s]     <= now_w[0];
               trip_out[s]      <= now_w[1];
               blocked_out[s]   <= now_w[2];
               stage_status[s]  <= st_out;
               ratio_now[s]     <= (ratio_w > 32'hFFFFFF) ? 24'hFFFFFF : ratio_w[23:0];
               time_left[s]     <= tmr_q;
               time_expected[s] <= op_delay[s];
               // Increment wins over clear
               start_count[s]   <= (now_w[0] & ~was_q[0]) ? start_count[s] + 16'h1 :
                                   cnt_clear ? 16'h0 : start_count[s];
               trip_count[s]    <= (now_w[1] & ~was_q[1]) ? trip_count[s] + 16'h1 :
                                   cnt_clear ? 16'h0 : trip_count[s];
               blocked_count[s] <= (now_w[2] & ~was_q[2]) ? blocked_count[s] + 16'h1 :
                                   cnt_clear ? 16'h0 : blocked_count[s];
            end
         end
      end
   endgenerate

   // Fault type: which phases are over the stage 0 setting
   generate
      for (p = 0; p < 3; p++) begin : g_ft
         assign fault_w[p] = mon_v[p] > set_value[0];
      end
   endgenerate

   // Only the lowest requesting stage is recorded
   logic [1:0] rec_stage;
   assign rec_stage = rec_req[0] ? 2'h0 : rec_req[1] ? 2'h1 : rec_req[2] ? 2'h2 : 2'h3;

   // Record store
   logic [31:0] r_time [`HOCS_REC_DEPTH];
   logic [4:0]  r_ev   [`HOCS_REC_DEPTH];
   logic [2:0]  r_ft   [`HOCS_REC_DEPTH];
   logic [15:0] r_pt   [`HOCS_REC_DEPTH];
   logic [15:0] r_fc   [`HOCS_REC_DEPTH];
   logic [15:0] r_pf   [`HOCS_REC_DEPTH];
   logic [15:0] r_tl   [`HOCS_REC_DEPTH];
   logic [2:0]  r_gr   [`HOCS_REC_DEPTH];
   logic [3:0]  wr_q, fill_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q   <= 4'h0;
         fill_q <= 4'h0;
         for (int i = 0; i < `HOCS_REC_DEPTH; i++) begin
            r_time[i] <= 32'h0;
            r_ev[i]   <= 5'h0;
            r_ft[i]   <= 3'h0;
            r_pt[i]   <= 16'h0;
            r_fc[i]   <= 16'h0;
            r_pf[i]   <= 16'h0;
            r_tl[i]   <= 16'h0;
            r_gr[i]   <= 3'h0;
         end
      end else if (clk_en && (|rec_req)) begin
         r_time[wr_q] <= timestamp;
         r_ev[wr_q]   <= {rec_stage, rec_kind[rec_stage][2:0]};
         r_ft[wr_q]   <= fault_w;
         r_pt[wr_q]   <= hist_q[PSH-1];
         r_fc[wr_q]   <= mon_max;
         r_pf[wr_q]   <= hist_q[PLG-1];
         r_tl[wr_q]   <= g_st[0].tmr_q;
         r_gr[wr_q]   <= set_group;
         wr_q   <= (wr_q == 4'(`HOCS_REC_DEPTH - 1)) ? 4'h0 : wr_q + 4'h1;
         fill_q <= (fill_q == 4'(`HOCS_REC_DEPTH)) ? fill_q : fill_q + 4'h1;
      end
   end

   logic [3:0] rd_w;
   assign rd_w = (rec_rd_idx >= 4'(`HOCS_REC_DEPTH)) ? 4'h0 : rec_rd_idx;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rec_time      <= 32'h0;
         rec_event     <= 5'h0;
         rec_fault     <= 3'h0;
         rec_pre_trig  <= 16'h0;
         rec_fault_cur <= 16'h0;
         rec_pre_fault <= 16'h0;
         rec_time_left <= 16'h0;
         rec_group     <= 3'h0;
         rec_fill      <= 4'h0;
      end else if (clk_en) begin
         rec_time      <= r_time[rd_w];
         rec_event     <= r_ev[rd_w];
         rec_fault     <= r_ft[rd_w];
         rec_pre_trig  <= r_pt[rd_w];
         rec_fault_cur <= r_fc[rd_w];
         rec_pre_fault <= r_pf[rd_w];
         rec_time_left <= r_tl[rd_w];
         rec_group     <= r_gr[rd_w];
         rec_fill      <= fill_q;
      end
   end

endmodule

// File: bench/hocs_stage_props.sv
// Concurrent checks on the harmonic overcurrent stage ports
`timescale 1ns/100ps
module hocs_stage_props (
   input wire logic             core_clk,
   input wire logic             rst_n,
   input wire logic             force_en,
   input wire logic [5:0]       ev_sel,
   input wire logic             cnt_clear,
   input wire logic [3:0]       start_out,
   input wire logic [3:0]       trip_out,
   input wire logic [3:0]       blocked_out,
   input wire logic [3:0][1:0]  stage_status,
   input wire logic [3:0][5:0]  event_pulse,
   input wire logic [3:0][15:0] start_count,
   input wire logic [3:0][15:0] trip_count,
   input wire logic [3:0][15:0] blocked_count,
   input wire logic [3:0]       rec_fill
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_start_rise;
      $rose(start_out[0]) && !force_en;
   endsequence
   sequence s_no_clear;
      !cnt_clear && !$past(cnt_clear);
   endsequence
   chk_start_event_on: assert property (s_start_rise ##0 ev_sel[0] |-> event_pulse[0][0])
      else $error("start on event missing");
   chk_event_one_cycle: assert property (event_pulse[0][0] |=> !event_pulse[0][0])
      else $error("event pulse longer than one cycle");
   chk_start_count_inc: assert property (s_start_rise ##0 s_no_clear
      |-> start_count[0] == $past(start_count[0]) + 16'h0001)
      else $error("start counter did not step");
   chk_trip_count_inc: assert property ($rose(trip_out[0]) ##0 s_no_clear
      |-> trip_count[0] == $past(trip_count[0]) + 16'h0001)
      else $error("trip counter did not step");
   chk_blk_count_inc: assert property ($rose(blocked_out[1]) ##0 s_no_clear
      |-> blocked_count[1] == $past(blocked_count[1]) + 16'h0001)
      else $error("blocked counter did not step");
   chk_start_blk_excl: assert property (!force_en |-> !(start_out[0] && blocked_out[0]))
      else $error("start and blocked together");
   chk_status_start: assert property (!force_en && start_out[0] && !trip_out[0]
      |-> stage_status[0] == hocs_pkg::HOCS_START)
      else $error("status not start");
   chk_status_trip: assert property (!force_en && trip_out[0]
      |-> stage_status[0] == hocs_pkg::HOCS_TRIP)
      else $error("status not trip");
   chk_fill_bound: assert property (rec_fill <= 4'hC)
      else $error("record fill above depth");
endmodule

// File: bench/hocs_meas_src.sv
// Harmonic measurement source and blocking matrix model
`timescale 1ns/100ps
module hocs_meas_src (
   input  wire logic             core_clk,
   input  wire logic [2:0][15:0] lvl_ph,
   input  wire logic [3:0]       block_req,
   output logic [15:0]           phase_harm [3][12],
   output logic [15:0]           phase_fund [3],
   output logic [15:0]           res1_harm [12],
   output logic [15:0]           res1_fund,
   output logic [15:0]           res2_harm [12],
   output logic [15:0]           res2_fund,
   output logic [3:0]            block_in
);
   // Unselected orders and residuals carry large values
   always_comb begin
      for (int h = 0; h < 12; h++) begin
         for (int p = 0; p < 3; p++) begin
            phase_harm[p][h] = (h == 0) ? lvl_ph[p] : 16'h0FFF;
         end
         res1_harm[h] = 16'h0FFF;
         res2_harm[h] = 16'h0FFF;
      end
      for (int p = 0; p < 3; p++) begin
         phase_fund[p] = 16'h0064;
      end
      res1_fund = 16'h0064;
      res2_fund = 16'h0064;
      block_in  = block_req;
   end
endmodule

// File: bench/hocs_harmonic_overcurrent_stage_tb_top.sv
// Testbench top of the harmonic overcurrent stage
`timescale 1ns/100ps
`include "hocs_consts.svh"
module hocs_harmonic_overcurrent_stage_tb_top;
   logic core_clk, rst_n, cnt_clear, force_en;
   logic [3:0][15:0] set_value, op_delay;
   logic [2:0][15:0] lvl_ph;
   logic [3:0] block_req, block_in, start_out, trip_out, blocked_out, rec_fill;
   logic [15:0] phase_harm [3][12];
   logic [15:0] phase_fund [3];
   logic [15:0] res1_harm [12], res2_harm [12];
   logic [15:0] res1_fund, res2_fund;
   logic [3:0][1:0] stage_status;
   logic [3:0][23:0] ratio_now;
   logic [3:0][5:0] event_pulse;
   logic [3:0][15:0] start_count, trip_count, blocked_count;
   logic [31:0] rec_time;
   logic [4:0] rec_event;
   logic [2:0] rec_group;
   logic [3:0] harm_sel;
   logic rel_mode;
   hocs_pkg::hocs_input_t meas_sel;
   logic [5:0] ev_sel;
   int n_mismatch, n_checks;
   localparam int TB_CYC = 64;
   hocs_meas_src i_src (.core_clk(core_clk), .lvl_ph(lvl_ph), .block_req(block_req),
      .phase_harm(phase_harm), .phase_fund(phase_fund), .res1_harm(res1_harm),
      .res1_fund(res1_fund), .res2_harm(res2_harm), .res2_fund(res2_fund),
      .block_in(block_in));
   hocs_harmonic_overcurrent_stage #(.CYCLE_CLKS(TB_CYC)) i_dut (.core_clk(core_clk),
      .rst_n(rst_n), .clk_en(1'b1),
      .harm_sel(harm_sel), .rel_mode(rel_mode), .meas_sel(meas_sel),
      .force_en(force_en), .force_state(hocs_pkg::HOCS_TRIP), .set_value(set_value),
      .op_delay(op_delay), .set_group(3'h5), .phase_harm(phase_harm),
      .phase_fund(phase_fund), .res1_harm(res1_harm), .res1_fund(res1_fund),
      .res2_harm(res2_harm), .res2_fund(res2_fund), .block_in(block_in),
      .ev_sel(ev_sel), .cnt_clear(cnt_clear), .timestamp(32'h00001234),
      .rec_rd_idx(4'h0), .start_out(start_out), .trip_out(trip_out),
      .blocked_out(blocked_out), .stage_status(stage_status), .ratio_now(ratio_now),
      .time_left(), .time_expected(), .event_pulse(event_pulse),
      .start_count(start_count), .trip_count(trip_count), .blocked_count(blocked_count),
      .rec_time(rec_time), .rec_event(rec_event), .rec_fault(), .rec_pre_trig(),
      .rec_fault_cur(), .rec_pre_fault(), .rec_time_left(), .rec_group(rec_group),
      .rec_fill(rec_fill));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Waits one program cycle and lets its outputs land
   task automatic next_tick();
      repeat (TB_CYC) @(posedge core_clk);
      repeat (2) @(negedge core_clk);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      repeat (14 * TB_CYC) @(posedge core_clk);
      n_mismatch++;
      final_report();
   end
   initial begin
      rst_n = 1'b0; cnt_clear = 1'b0; force_en = 1'b0;
      harm_sel = 4'hC;
      rel_mode = 1'b0;
      meas_sel = hocs_pkg::HOCS_IN_PHASE;
      ev_sel = 6'h3F;
      set_value = {16'hFFFF, 16'hFFFF, 16'h0014, 16'h0014};
      op_delay = {16'h00FF, 16'h00FF, 16'h00FF, 16'h0002};
      lvl_ph = {16'h0000, 16'h001E, 16'h0000};
      block_req = 4'h2;
      repeat (20) @(negedge core_clk);
      rst_n = 1'b1;
      check(start_out, 4'h0);
      check(rec_fill, 4'h0);
      check(start_count[0], 16'h0000);
      next_tick();
      check(start_out, 4'h1);
      check(blocked_out, 4'h2);
      check(stage_status[0], hocs_pkg::HOCS_START);
      check(ratio_now[0], 24'h000096);
      check(start_count[0], 16'h0001);
      check(blocked_count[1], 16'h0001);
      @(negedge core_clk);
      check(rec_fill, 4'h1);
      check(rec_event, 5'h01);
      check(rec_time, 32'h00001234);
      check(rec_group, 3'h5);
      cnt_clear = 1'b1;
      repeat (2) @(negedge core_clk);
      cnt_clear = 1'b0;
      repeat (2) @(negedge core_clk);
      check(start_count[0], 16'h0000);
      check(blocked_count[1], 16'h0000);
      lvl_ph[1] = 16'h0014;
      block_req = 4'h0;
      set_value[3] = 16'h0010;
      next_tick();
      check(start_out, 4'h9);
      check(blocked_out, 4'h0);
      check(trip_out, 4'h0);
      block_req = 4'h8;
      next_tick();
      check(trip_out[0], 1'b1);
      check(start_out[3], 1'b0);
      check(trip_count[0], 16'h0001);
      lvl_ph[1] = 16'h0013;
      next_tick();
      check(trip_out[0], 1'b1);
      lvl_ph[1] = 16'h0012;
      next_tick();
      check(start_out, 4'h0);
      check(trip_out, 4'h0);
      check(stage_status[0], hocs_pkg::HOCS_NORMAL);
      force_en = 1'b1;
      repeat (2) @(negedge core_clk);
      check(stage_status[0], hocs_pkg::HOCS_TRIP);
      check(trip_out[0], 1'b1);
      final_report();
   end
endmodule
bind hocs_harmonic_overcurrent_stage hocs_stage_props i_props (.core_clk(core_clk),
   .rst_n(rst_n), .force_en(force_en), .ev_sel(ev_sel), .cnt_clear(cnt_clear),
   .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
   .stage_status(stage_status), .event_pulse(event_pulse), .start_count(start_count),
   .trip_count(trip_count), .blocked_count(blocked_count), .rec_fill(rec_fill));
